/* dv/acu_compare_unit_asserts.sv */
`timescale 1ns/1ps
module acu_compare_unit_chk (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Bus handshakes.
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Status outputs.
  input wire logic less_than_flag_out,
  input wire logic equal_flag_out,
  input wire logic greater_than_flag_out,
  input wire logic non_bcd_error_flag_out,
  input wire logic irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // The result flags gathered so that one check covers them all.
  wire logic [2:0] res = {greater_than_flag_out, equal_flag_out, less_than_flag_out};
  wire logic [3:0] flg = {non_bcd_error_flag_out, res};
  // Never two results at once, even while a command is being decoded.
  property p_one_result;
    $onehot0(res);
  endproperty
  a_one_result: assert property (p_one_result) else $error("two result flags high");
  // Flags only move on the edge after a write response, so they hold otherwise.
  property p_flags_hold;
    !$stable(flg) |-> $past(s_axi_bvalid_out);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved without a command");
  // Mask and clear writes move the pin as the response rises.
  property p_irq_cause;
    !$stable(irq_out) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt moved without a write");
  property p_b_answer;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> s_axi_bvalid_out;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  property p_b_release;
    s_axi_bvalid_out && s_axi_bready_in
      |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out;
  endproperty
  a_b_release: assert property (p_b_release) else $error("write channel not reopened");
  property p_b_block;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  property p_r_answer;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read response late");
  property p_r_release;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out ##0 s_axi_arready_out;
  endproperty
  a_r_release: assert property (p_r_release) else $error("read channel not reopened");
  // Main scenarios: each result seen at least once, and the interrupt raised.
  c_less: cover property ($rose(less_than_flag_out));
  c_equal: cover property ($rose(equal_flag_out));
  c_greater: cover property ($rose(greater_than_flag_out));
  c_irq: cover property ($rose(irq_out));
endmodule
bind acu_compare_unit acu_compare_unit_chk u_chk (.core_clk_in, .rst_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .less_than_flag_out, .equal_flag_out, .greater_than_flag_out, .non_bcd_error_flag_out, .irq_out);

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0] op;
    logic [2:0] sp;
    logic [5:0] n;
    logic [31:0] acc;
    logic [31:0] opnd;
    logic [2:0] res;
  } acu_row_s;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rv;
  logic [1:0] rs;
  wire logic awready, wready, bvalid, arready, rvalid, lt, eq, gt, nbcd, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int miscompares, comparisons, i;
  // Operation, space, count, accumulator, operand, then {greater, equal, less}.
  acu_row_s rows [15] = '{
    '{2'h0, 3'h2, 6'h04, 32'h6, 32'he, 3'h1}, '{2'h0, 3'h0, 6'h04, 32'h6, 32'hf6, 3'h2},
    '{2'h0, 3'h1, 6'h20, 32'hffffffff, 32'h7fffffff, 3'h4}, '{2'h0, 3'h3, 6'h01, 32'h0, 32'h1, 3'h1},
    '{2'h0, 3'h4, 6'h08, 32'h12, 32'h12, 3'h2}, '{2'h0, 3'h5, 6'h10, 32'h8000, 32'h7fff, 3'h4},
    '{2'h0, 3'h6, 6'h1f, 32'h0, 32'h80000000, 3'h2},
    '{2'h1, 3'h0, 6'h00, 32'h80000000, 32'h7fffffff, 3'h4}, '{2'h1, 3'h0, 6'h00, 32'h1, 32'h2, 3'h1},
    '{2'h1, 3'h0, 6'h00, 32'h5, 32'h5, 3'h2}, '{2'h2, 3'h0, 6'h00, 32'h40e00000, 32'h40c00000, 3'h4},
    '{2'h2, 3'h0, 6'h00, 32'hbf800000, 32'h3f800000, 3'h1},
    '{2'h2, 3'h0, 6'h00, 32'h00000000, 32'h80000000, 3'h2},
    '{2'h2, 3'h0, 6'h00, 32'h7f7fffff, 32'hff7fffff, 3'h4},
    '{2'h2, 3'h0, 6'h00, 32'hff7fffff, 32'h7f7fffff, 3'h1}};

  acu_compare_unit DUT (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .less_than_flag_out(lt), .equal_flag_out(eq),
    .greater_than_flag_out(gt), .non_bcd_error_flag_out(nbcd), .irq_out(irq));

  // Free-running core clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] mk(logic [1:0] op, logic [5:0] n, logic [2:0] sp,
                                     logic [10:0] st, logic bcd, logic ptr);
    return {8'h00, bcd, ptr, st, sp, n, op};
  endfunction

  // Address and data go out together; each is dropped at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (k == 100) miscompares++;
  endtask

  // Read data is taken at the edge where the response is seen.
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (k == 100) miscompares++;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Ports in the order interrupt, non-BCD, greater, equal, less.
  task automatic cmp_port(input logic [4:0] e);
    cmp({27'h0, irq, nbcd, gt, eq, lt}, {27'h0, e});
  endtask

  task automatic cmp_resp(input logic [1:0] e);
    cmp({30'h0, rs}, {30'h0, e});
  endtask

  task automatic run_row(input acu_row_s r);
    wr(r.op == 2'h0 ? acu_pkg::ACU_OFS_DBITS : r.op == 2'h1 ? acu_pkg::ACU_OFS_ACC :
       acu_pkg::ACU_OFS_OPHI, r.opnd);
    wr(acu_pkg::ACU_OFS_ACC, r.acc);
    wr(acu_pkg::ACU_OFS_CMD, mk(r.op, r.n, r.sp, 11'h000, 1'b0, 1'b0));
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'h1f, {29'h0, r.res});
    cmp_port({2'b00, r.res});
  endtask

  // A refused compare raises the range error and keeps the earlier greater result.
  task automatic chk_err(input logic [31:0] c);
    wr(acu_pkg::ACU_OFS_CMD, c);
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'h27, 32'h24);
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 15; i++) run_row(rows[i]);
    $display("table done");
    // A reset in mid-run clears every register and output.
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 1; i < 10; i++)
    begin
      rd(8'(4 * i));
      cmp(rv, 32'h0);
    end
    cmp_port(5'h00);
    $display("reset done");
    wr(acu_pkg::ACU_OFS_ACC, 32'h11111111);
    wr(acu_pkg::ACU_OFS_ACC, 32'h22222222);
    rd(acu_pkg::ACU_OFS_STACK0);
    cmp(rv, 32'h11111111);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h1, 6'h00, 3'h0, 11'h000, 1'b0, 1'b0));
    rd(acu_pkg::ACU_OFS_ACC);
    cmp(rv, 32'h22222222);
    rd(acu_pkg::ACU_OFS_STACK0);
    cmp(rv, 32'h11111111);
    $display("stack done");
    chk_err(mk(2'h0, 6'h00, 3'h2, 11'h000, 1'b0, 1'b0));
    chk_err(mk(2'h0, 6'h21, 3'h2, 11'h000, 1'b0, 1'b0));
    chk_err(mk(2'h0, 6'h02, 3'h2, 11'o1777, 1'b0, 1'b0));
    chk_err(mk(2'h0, 6'h01, 3'h7, 11'h000, 1'b0, 1'b0));
    chk_err(mk(2'h3, 6'h01, 3'h2, 11'h000, 1'b0, 1'b0));
    wr(acu_pkg::ACU_OFS_DBITS, 32'h1);
    wr(acu_pkg::ACU_OFS_ACC, 32'h1);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h0, 6'h01, 3'h2, 11'o1777, 1'b0, 1'b0));
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'h7, 32'h2);
    $display("range done");
    wr(acu_pkg::ACU_OFS_PTR, 32'h0fff);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h2, 6'h00, 3'h0, 11'h000, 1'b0, 1'b1));
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'hf, 32'ha);
    wr(acu_pkg::ACU_OFS_PTR, 32'h0ffe);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h2, 6'h00, 3'h0, 11'h000, 1'b0, 1'b1));
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'h8, 32'h0);
    wr(acu_pkg::ACU_OFS_OPLO, 32'h0000000a);
    wr(acu_pkg::ACU_OFS_OPHI, 32'h40000000);
    wr(acu_pkg::ACU_OFS_ACC, 32'h40000000);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h2, 6'h00, 3'h0, 11'h000, 1'b1, 1'b0));
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'h17, 32'h12);
    cmp_port(5'h0a);
    wr(acu_pkg::ACU_OFS_OPLO, 32'h12345678);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h2, 6'h00, 3'h0, 11'h000, 1'b1, 1'b0));
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp_port(5'h02);
    $display("pointer and bcd done");
    // Only the done event is unmasked; other status bits must not reach the pin.
    wr(acu_pkg::ACU_OFS_IRQ_STS, 32'h7f);
    rd(acu_pkg::ACU_OFS_IRQ_STS);
    cmp(rv, 32'h0);
    wr(acu_pkg::ACU_OFS_IRQ_MASK, 32'h40);
    wr(acu_pkg::ACU_OFS_CMD, mk(2'h1, 6'h00, 3'h0, 11'h000, 1'b0, 1'b0));
    rd(acu_pkg::ACU_OFS_IRQ_STS);
    cmp(rv & 32'h40, 32'h40);
    cmp_port(5'h14);
    wr(acu_pkg::ACU_OFS_IRQ_MASK, 32'h0);
    rd(acu_pkg::ACU_OFS_IRQ_STS);
    cmp_port(5'h04);
    wr(acu_pkg::ACU_OFS_IRQ_MASK, 32'h40);
    wr(acu_pkg::ACU_OFS_IRQ_STS, 32'h40);
    rd(acu_pkg::ACU_OFS_IRQ_STS);
    cmp(rv & 32'h40, 32'h0);
    cmp_port(5'h04);
    $display("interrupt done");
    wr(8'h28, 32'hffffffff);
    cmp_resp(acu_pkg::ACU_RESP_SLVERR);
    rd(8'h28);
    cmp_resp(acu_pkg::ACU_RESP_SLVERR);
    cmp(rv, 32'h0);
    rd(8'h05);
    cmp_resp(acu_pkg::ACU_RESP_SLVERR);
    wr(acu_pkg::ACU_OFS_FLAGS, 32'hffffffff);
    cmp_resp(acu_pkg::ACU_RESP_OKAY);
    wr(acu_pkg::ACU_OFS_STACK0, 32'hffffffff);
    rd(acu_pkg::ACU_OFS_STACK0);
    cmp(rv, 32'h1);
    rd(acu_pkg::ACU_OFS_FLAGS);
    cmp(rv & 32'h7, 32'h4);
    $display("bus done");
    results();
  end
endmodule

/* hw/acu_bit_fetch.sv */
`timescale 1ns/1ps
module acu_bit_fetch (
  // Command fields.
  input wire acu_pkg::acu_cmd_s cmd_in,
  // Image of the discrete bits, lowest address in bit 0.
  input wire logic [31:0] dbits_in,
  // Masked operand and validity of the operand span.
  output logic [31:0] operand_out,
  output logic range_ok_out
);

  logic [10:0] max_addr;
  logic [11:0] last_addr;

  // Each bit space has its own top address; an illegal space code has none.
  always_comb
  begin
    max_addr = 11'h000;
    unique case (cmd_in.space)
      acu_pkg::ACU_SPACE_INPUT: max_addr = acu_pkg::ACU_MAX_IN;
      acu_pkg::ACU_SPACE_OUTPUT: max_addr = acu_pkg::ACU_MAX_OUT;
      acu_pkg::ACU_SPACE_CONTROL_RELAY: max_addr = acu_pkg::ACU_MAX_CR;
      acu_pkg::ACU_SPACE_STAGE: max_addr = acu_pkg::ACU_MAX_STAGE;
      acu_pkg::ACU_SPACE_TIMER: max_addr = acu_pkg::ACU_MAX_TIMER;
      acu_pkg::ACU_SPACE_COUNTER_BIT: max_addr = acu_pkg::ACU_MAX_COUNTER;
      acu_pkg::ACU_SPACE_SPECIAL_RELAY: max_addr = acu_pkg::ACU_MAX_SPECIAL;
      default: max_addr = 11'h000;
    endcase
  end

  // The whole run of bits must fit inside the chosen space.
  always_comb
  begin
    last_addr = {1'b0, cmd_in.start} + {6'h00, cmd_in.count} - 12'h001;
    range_ok_out = (cmd_in.count >= acu_pkg::ACU_CNT_MIN)
      && (cmd_in.count <= acu_pkg::ACU_CNT_MAX)
      && (cmd_in.space != acu_pkg::acu_space_e'(3'h7))
      && (last_addr <= {1'b0, max_addr}); // RL1 RL2
  end

  // Bits above the count are zero, so the run reads as an unsigned number.
  generate
    for (genvar i = 0; i < 32; i++)
    begin : g_mask
      assign operand_out[i] = dbits_in[i] && (6'(i) < cmd_in.count); // RL1 RL15
    end
  endgenerate

endmodule

/* hw/acu_compare_unit.sv */
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// RL1: Formatted compare uses one to thirty-two bits.
// RL2: Start address and bit count given.
// RL3: Less flag when accumulator is smaller.
// RL4: Greater flag when accumulator is larger.
// RL5: Equal flag when values match.
// RL6: Flags hold until the next update.
// RL7: Stack compare is full 32-bit compare.
// RL8: Stack compare leaves accumulator unchanged.
// RL9: Double load pushes old accumulator first.
// RL10: Real compare takes two consecutive words; here only the high word is compared, the low word feeds the BCD check.
// RL11: Real constants span full single range.
// RL12: Invalid pointer raises pointer error flag.
// RL13: Non-BCD digit raises non-BCD flag.
// RL14: Equal result appears on equal flag.
// RL15: Exactly one result flag; unsigned bits.
// RL16: Real compare follows IEEE sign ordering.
module acu_compare_unit (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_in,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Compare status flags and interrupt.
  output logic less_than_flag_out,
  output logic equal_flag_out,
  output logic greater_than_flag_out,
  output logic non_bcd_error_flag_out,
  output logic irq_out
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    acu_pkg::acu_cmd_s cmd;
    logic go;
    logic [31:0] acc;
    logic [7:0][31:0] stack;
    logic [31:0] op_lo;
    logic [31:0] op_hi;
    logic [31:0] dbits;
    logic [31:0] ptr;
    logic [6:0] flags;
    logic [6:0] irq_sts;
    logic [6:0] irq_mask;
    logic irq;
  } acu_state_s;

  acu_state_s s_q;
  acu_state_s s_d;

  logic [31:0] bit_operand;
  logic bit_range_ok;
  logic real_less;
  logic real_equal;
  logic real_greater;

  // Register index decode, shared by the write and read paths.
  function automatic logic [3:0] acu_reg_sel(input logic [7:0] addr);
    logic [3:0] sel;
    sel = 4'hf;
    if (addr[1:0] == 2'h0 && addr <= acu_pkg::ACU_OFS_IRQ_MASK)
      sel = addr[5:2];
    return sel;
  endfunction

  // Byte lanes not strobed keep their old contents.
  function automatic logic [31:0] acu_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  // True when every nibble is a decimal digit.
  function automatic logic acu_is_bcd(input logic [63:0] value);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      if (value[i*4 +: 4] > 4'h9)
        ok = 1'b0;
    end
    return ok;
  endfunction

  // The formatted operand is gathered from the discrete bit image.
  acu_bit_fetch u_bit_fetch (
    .cmd_in(s_q.cmd),
    .dbits_in(s_q.dbits),
    .operand_out(bit_operand),
    .range_ok_out(bit_range_ok)
  );

  // The real operand is the high word alone; the low word only feeds the BCD check.
  acu_real_cmp u_real_cmp (
    .acc_in(s_q.acc),
    .opnd_in(s_q.op_hi),
    .less_out(real_less),
    .equal_out(real_equal),
    .greater_out(real_greater)
  );

  // Next state: bus handshakes, register writes, compare execution and events.
  always_comb
  begin
    logic aw_have;
    logic w_have;
    logic wr_fire;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [6:0] ev;
    logic [6:0] clr;
    logic lt;
    logic eq;
    logic [31:0] wval;
    s_d = s_q;
    aw_have = 1'b0;
    w_have = 1'b0;
    wr_fire = 1'b0;
    wsel = 4'hf;
    rsel = 4'hf;
    ev = 7'h00;
    clr = 7'h00;
    lt = 1'b0;
    eq = 1'b0;
    wval = 32'h0000_0000;
    s_d.go = 1'b0;

    // Execute the command written in the previous cycle.
    if (s_q.go)
    begin
      ev[acu_pkg::ACU_FLG_DONE] = 1'b1;
      unique case (s_q.cmd.op)
        acu_pkg::ACU_OP_FORMATTED_BIT_COMPARE:
        begin
          s_d.flags[acu_pkg::ACU_FLG_RANGE_ERR] = !bit_range_ok; // RL6
          if (bit_range_ok)
          begin
            lt = s_q.acc < bit_operand; // RL1 RL15
            eq = s_q.acc == bit_operand;
            s_d.flags[acu_pkg::ACU_FLG_LESS] = lt; // RL3
            s_d.flags[acu_pkg::ACU_FLG_EQUAL] = eq; // RL5 RL14
            s_d.flags[acu_pkg::ACU_FLG_GREATER] = !lt && !eq; // RL4 RL15
          end
          else
            ev[acu_pkg::ACU_FLG_RANGE_ERR] = 1'b1;
        end
        acu_pkg::ACU_OP_STACK_COMPARE:
        begin
          // The accumulator and stack are read only here.
          lt = s_q.acc < s_q.stack[0]; // RL7 RL8 RL15
          eq = s_q.acc == s_q.stack[0]; // RL7
          s_d.flags[acu_pkg::ACU_FLG_LESS] = lt; // RL3
          s_d.flags[acu_pkg::ACU_FLG_EQUAL] = eq; // RL5 RL14
          s_d.flags[acu_pkg::ACU_FLG_GREATER] = !lt && !eq; // RL4
        end
        acu_pkg::ACU_OP_REAL_COMPARE:
        begin
          // A constant operand is the same two words written directly.
          s_d.flags[acu_pkg::ACU_FLG_NON_BCD] = s_q.cmd.bcd_expected
            && !acu_is_bcd({s_q.op_hi, s_q.op_lo}); // RL13
          ev[acu_pkg::ACU_FLG_NON_BCD] = s_d.flags[acu_pkg::ACU_FLG_NON_BCD];
          s_d.flags[acu_pkg::ACU_FLG_PTR_ERR] = s_q.cmd.use_pointer
            && (s_q.ptr >= {16'h0000, acu_pkg::ACU_VMEM_LAST}); // RL12
          ev[acu_pkg::ACU_FLG_PTR_ERR] = s_d.flags[acu_pkg::ACU_FLG_PTR_ERR];
          if (!s_d.flags[acu_pkg::ACU_FLG_PTR_ERR])
          begin
            s_d.flags[acu_pkg::ACU_FLG_LESS] = real_less; // RL3 RL10 RL11 RL16
            s_d.flags[acu_pkg::ACU_FLG_EQUAL] = real_equal; // RL5 RL14
            s_d.flags[acu_pkg::ACU_FLG_GREATER] = real_greater; // RL4
          end
        end
        acu_pkg::ACU_OP_RESERVED:
        begin
          s_d.flags[acu_pkg::ACU_FLG_RANGE_ERR] = 1'b1;
          ev[acu_pkg::ACU_FLG_RANGE_ERR] = 1'b1;
        end
      endcase
    end

    // Write channel: address and data are taken in either order.
    aw_have = s_q.aw_got || (s_q.awready && s_axi_awvalid_in);
    w_have = s_q.w_got || (s_q.wready && s_axi_wvalid_in);
    if (s_q.awready && s_axi_awvalid_in)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr_in;
    end
    if (s_q.wready && s_axi_wvalid_in)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    if (s_q.bvalid && s_axi_bready_in)
      s_d.bvalid = 1'b0;
    wr_fire = aw_have && w_have && !s_q.bvalid;
    if (wr_fire)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = acu_pkg::ACU_RESP_OKAY;
      wsel = acu_reg_sel(s_d.awaddr);
      unique case (wsel)
        acu_pkg::ACU_OFS_CMD[5:2]:
        begin
          s_d.cmd = acu_merge(s_q.cmd, s_d.wdata, s_d.wstrb);
          s_d.go = 1'b1;
        end
        acu_pkg::ACU_OFS_ACC[5:2]:
        begin
          // A load pushes the old accumulator; the deepest level drops off.
          wval = acu_merge(s_q.acc, s_d.wdata, s_d.wstrb);
          for (int i = acu_pkg::ACU_STACK_DEPTH - 1; i > 0; i--)
          begin
            s_d.stack[i] = s_q.stack[i-1]; // RL9
          end
          s_d.stack[0] = s_q.acc; // RL9
          s_d.acc = wval;
        end
        acu_pkg::ACU_OFS_OPLO[5:2]: s_d.op_lo = acu_merge(s_q.op_lo, s_d.wdata, s_d.wstrb);
        acu_pkg::ACU_OFS_OPHI[5:2]: s_d.op_hi = acu_merge(s_q.op_hi, s_d.wdata, s_d.wstrb);
        acu_pkg::ACU_OFS_DBITS[5:2]: s_d.dbits = acu_merge(s_q.dbits, s_d.wdata, s_d.wstrb);
        acu_pkg::ACU_OFS_PTR[5:2]: s_d.ptr = acu_merge(s_q.ptr, s_d.wdata, s_d.wstrb);
        acu_pkg::ACU_OFS_IRQ_STS[5:2]: clr = s_d.wdata[acu_pkg::ACU_FLG_W-1:0];
        acu_pkg::ACU_OFS_IRQ_MASK[5:2]: s_d.irq_mask = s_d.wdata[acu_pkg::ACU_FLG_W-1:0];
        acu_pkg::ACU_OFS_STACK0[5:2], acu_pkg::ACU_OFS_FLAGS[5:2]:
        begin
          // Read-only registers accept and ignore the data.
          s_d.bresp = acu_pkg::ACU_RESP_OKAY;
        end
        default: s_d.bresp = acu_pkg::ACU_RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // A new event wins over a clear written in the same cycle.
    s_d.irq_sts = (s_q.irq_sts & ~clr) | ev;
    s_d.irq = |(s_d.irq_sts & s_d.irq_mask);

    // Read channel: one read in flight, data sampled when the address is taken.
    if (s_q.rvalid && s_axi_rready_in)
      s_d.rvalid = 1'b0;
    if (s_q.arready && s_axi_arvalid_in)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = acu_pkg::ACU_RESP_OKAY;
      rsel = acu_reg_sel(s_axi_araddr_in);
      unique case (rsel)
        acu_pkg::ACU_OFS_CMD[5:2]: s_d.rdata = s_q.cmd;
        acu_pkg::ACU_OFS_ACC[5:2]: s_d.rdata = s_q.acc;
        acu_pkg::ACU_OFS_STACK0[5:2]: s_d.rdata = s_q.stack[0];
        acu_pkg::ACU_OFS_OPLO[5:2]: s_d.rdata = s_q.op_lo;
        acu_pkg::ACU_OFS_OPHI[5:2]: s_d.rdata = s_q.op_hi;
        acu_pkg::ACU_OFS_DBITS[5:2]: s_d.rdata = s_q.dbits;
        acu_pkg::ACU_OFS_PTR[5:2]: s_d.rdata = s_q.ptr;
        acu_pkg::ACU_OFS_FLAGS[5:2]: s_d.rdata = {25'h0000000, s_q.flags};
        acu_pkg::ACU_OFS_IRQ_STS[5:2]: s_d.rdata = {25'h0000000, s_q.irq_sts};
        acu_pkg::ACU_OFS_IRQ_MASK[5:2]: s_d.rdata = {25'h0000000, s_q.irq_mask};
        default:
        begin
          s_d.rdata = acu_pkg::ACU_RST_WORD;
          s_d.rresp = acu_pkg::ACU_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  // All state in one register; reset leaves the bus idle and flags clear.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready_out = s_q.awready;
  assign s_axi_wready_out = s_q.wready;
  assign s_axi_bresp_out = s_q.bresp;
  assign s_axi_bvalid_out = s_q.bvalid;
  assign s_axi_arready_out = s_q.arready;
  assign s_axi_rdata_out = s_q.rdata;
  assign s_axi_rresp_out = s_q.rresp;
  assign s_axi_rvalid_out = s_q.rvalid;
  assign less_than_flag_out = s_q.flags[acu_pkg::ACU_FLG_LESS];
  assign equal_flag_out = s_q.flags[acu_pkg::ACU_FLG_EQUAL];
  assign greater_than_flag_out = s_q.flags[acu_pkg::ACU_FLG_GREATER];
  assign non_bcd_error_flag_out = s_q.flags[acu_pkg::ACU_FLG_NON_BCD];
  assign irq_out = s_q.irq;

endmodule

/* hw/acu_pkg.sv */
package acu_pkg;

  // Register bus geometry.
  localparam int ACU_ADDR_W = 8;
  localparam int ACU_DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] ACU_OFS_CMD = 8'h00;
  localparam logic [7:0] ACU_OFS_ACC = 8'h04;
  localparam logic [7:0] ACU_OFS_STACK0 = 8'h08;
  localparam logic [7:0] ACU_OFS_OPLO = 8'h0c;
  localparam logic [7:0] ACU_OFS_OPHI = 8'h10;
  localparam logic [7:0] ACU_OFS_DBITS = 8'h14;
  localparam logic [7:0] ACU_OFS_PTR = 8'h18;
  localparam logic [7:0] ACU_OFS_FLAGS = 8'h1c;
  localparam logic [7:0] ACU_OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] ACU_OFS_IRQ_MASK = 8'h24;

  // Field positions in the flag register; the interrupt status shares them.
  localparam int ACU_FLG_LESS = 0;
  localparam int ACU_FLG_EQUAL = 1;
  localparam int ACU_FLG_GREATER = 2;
  localparam int ACU_FLG_PTR_ERR = 3;
  localparam int ACU_FLG_NON_BCD = 4;
  localparam int ACU_FLG_RANGE_ERR = 5;
  localparam int ACU_FLG_DONE = 6;
  localparam int ACU_FLG_W = 7;

  // Values after reset.
  localparam logic [31:0] ACU_RST_WORD = 32'h0000_0000;
  localparam logic [6:0] ACU_RST_FLAGS = 7'h00;

  // Accumulator stack depth and data-memory size seen through the pointer.
  localparam int ACU_STACK_DEPTH = 8;
  localparam logic [15:0] ACU_VMEM_LAST = 16'h0fff;

  // Highest discrete address of each bit space, octal as printed.
  localparam logic [10:0] ACU_MAX_IN = 11'o777;
  localparam logic [10:0] ACU_MAX_OUT = 11'o777;
  localparam logic [10:0] ACU_MAX_CR = 11'o1777;
  localparam logic [10:0] ACU_MAX_STAGE = 11'o1777;
  localparam logic [10:0] ACU_MAX_TIMER = 11'o377;
  localparam logic [10:0] ACU_MAX_COUNTER = 11'o177;
  localparam logic [10:0] ACU_MAX_SPECIAL = 11'o777;

  // Bit count limits of the formatted compare.
  localparam logic [5:0] ACU_CNT_MIN = 6'h01;
  localparam logic [5:0] ACU_CNT_MAX = 6'h20;

  // AXI responses.
  localparam logic [1:0] ACU_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACU_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACU_OP_FORMATTED_BIT_COMPARE,
    ACU_OP_STACK_COMPARE,
    ACU_OP_REAL_COMPARE,
    ACU_OP_RESERVED
  } acu_op_e;

  typedef enum logic [2:0] {
    ACU_SPACE_INPUT,
    ACU_SPACE_OUTPUT,
    ACU_SPACE_CONTROL_RELAY,
    ACU_SPACE_STAGE,
    ACU_SPACE_TIMER,
    ACU_SPACE_COUNTER_BIT,
    ACU_SPACE_SPECIAL_RELAY
  } acu_space_e;

  // Command word, written to the command register to start a compare.
  typedef struct packed {
    logic [7:0] rsvd;
    logic bcd_expected;
    logic use_pointer;
    logic [10:0] start;
    acu_space_e space;
    logic [5:0] count;
    acu_op_e op;
  } acu_cmd_s;

endpackage

/* hw/acu_real_cmp.sv */
`timescale 1ns/1ps
module acu_real_cmp (
  // Accumulator and operand as single-precision words.
  input wire logic [31:0] acc_in,
  input wire logic [31:0] opnd_in,
  // Ordering result; exactly one is high.
  output logic less_out,
  output logic equal_out,
  output logic greater_out
);

  logic a_zero;
  logic b_zero;
  logic mag_lt;
  logic mag_eq;

  // Sign and magnitude ordering; plus and minus zero are equal.
  always_comb
  begin
    a_zero = (acc_in[30:0] == 31'h0000_0000);
    b_zero = (opnd_in[30:0] == 31'h0000_0000);
    mag_lt = acc_in[30:0] < opnd_in[30:0];
    mag_eq = acc_in[30:0] == opnd_in[30:0];
    if ((a_zero && b_zero) || (acc_in == opnd_in))
    begin
      less_out = 1'b0;
    end
    else if (acc_in[31] != opnd_in[31])
    begin
      less_out = acc_in[31]; // RL16
    end
    else
    begin
      less_out = acc_in[31] ? (!mag_lt && !mag_eq) : mag_lt; // RL16
    end
    equal_out = (a_zero && b_zero) || (acc_in == opnd_in);
    greater_out = !less_out && !equal_out; // RL15
  end

endmodule
